// ---- verilog/odec_map.vh ----
// constants for the opcode decoder and address generator
// assumes inclusion by the decoder, its table and its checker
`ifndef ODEC_MAP_VH
`define ODEC_MAP_VH

// one-hot addressing mode bit positions
`define ODEC_MODE_W      10
`define ODEC_M_IMPL      4'h0
`define ODEC_M_CONST     4'h1
`define ODEC_M_PAGE0     4'h2
`define ODEC_M_ABS       4'h3
`define ODEC_M_RIDX      4'h4
`define ODEC_M_BOFF      4'h5
`define ODEC_M_WOFF      4'h6
`define ODEC_M_BRANCH    4'h7
`define ODEC_M_BITMOD    4'h8
`define ODEC_M_BITTEST   4'h9

// per-flag update policy codes, three bits per flag
`define ODEC_FP_W        3
`define ODEC_FPOL_W      15
`define ODEC_FP_KEEP     3'h0
`define ODEC_FP_TEST     3'h1
`define ODEC_FP_CLR      3'h2
`define ODEC_FP_SET      3'h3
`define ODEC_FP_STACK    3'h4

// condition flag positions
`define ODEC_F_H         4
`define ODEC_F_I         3
`define ODEC_F_N         2
`define ODEC_F_Z         1
`define ODEC_F_C         0

// opcode fields
`define ODEC_HI          7:4
`define ODEC_LO          3:0
`define ODEC_BITNUM      3:1
`define ODEC_BITPOL      0

// instruction lengths and reset values
`define ODEC_LEN1        2'h1
`define ODEC_LEN2        2'h2
`define ODEC_LEN3        2'h3
`define ODEC_ZERO8       8'h00
`define ODEC_ZERO16      16'h0000
`define ODEC_ONE16       16'h0001
`define ODEC_TWO16       16'h0002
`define ODEC_THREE16     16'h0003
`define ODEC_OP_BSR      8'hAD
`define ODEC_OP_NOP      8'h9D

`endif

// ---- verilog/odec_attr_rom.v ----
// opcode attribute table: mode, length, legality and flag policy
// assumes opcode_in holds a valid byte in the cycle it is sampled
`timescale 1ns/1ns
`include "odec_map.vh"

module odec_attr_rom (
  // clock and reset
  input  wire                      clk_in,
  input  wire                      resetn_in,
  // lookup
  input  wire [7:0]                opcode_in,
  output reg  [`ODEC_MODE_W-1:0]   mode_out,
  output reg  [1:0]                len_out,
  output reg                       illegal_out,
  output reg  [`ODEC_FPOL_W-1:0]   fpol_out
);

  // addressing mode column from the high nibble
  function [`ODEC_MODE_W-1:0] mode_of;
    input [7:0] op;
    reg   [3:0] m;
    begin
      case (op[`ODEC_HI])
        4'h0: m = `ODEC_M_BITTEST;
        4'h1: m = `ODEC_M_BITMOD;
        4'h2: m = `ODEC_M_BRANCH;
        4'h3, 4'hB: m = `ODEC_M_PAGE0;
        4'h6, 4'hE: m = `ODEC_M_BOFF;
        4'h7, 4'hF: m = `ODEC_M_RIDX;
        4'hA: m = (op == `ODEC_OP_BSR) ? `ODEC_M_BRANCH : `ODEC_M_CONST;
        4'hC: m = `ODEC_M_ABS;
        4'hD: m = `ODEC_M_WOFF;
        default: m = `ODEC_M_IMPL;
      endcase
      mode_of = {{(`ODEC_MODE_W-1){1'b0}}, 1'b1} << m;
    end
  endfunction

  // holes in the opcode map
  function legal_of;
    input [7:0] op;
    reg   [3:0] lo;
    begin
      lo = op[`ODEC_LO];
      case (op[`ODEC_HI])
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
          legal_of = !(lo == 4'h1 || lo == 4'h2 || lo == 4'h5 ||
                       lo == 4'hB || lo == 4'hE) || op == 8'h42;
        4'h8: legal_of = (lo == 4'h0 || lo == 4'h1 || lo == 4'h3 ||
                          lo == 4'hE || lo == 4'hF);
        4'h9: legal_of = (lo >= 4'h7 && lo != 4'hE);
        4'hA: legal_of = !(lo == 4'h7 || lo == 4'hC || lo == 4'hF);
        default: legal_of = 1'b1;
      endcase
    end
  endfunction

  // flag update policy, packed {h,i,n,z,c}
  function [`ODEC_FPOL_W-1:0] fpol_of;
    input [7:0] op;
    reg   [2:0] h, i, n, z, c;
    reg   [3:0] lo;
    begin
      lo = op[`ODEC_LO];
      h = `ODEC_FP_KEEP;
      i = `ODEC_FP_KEEP;
      n = `ODEC_FP_KEEP;
      z = `ODEC_FP_KEEP;
      c = `ODEC_FP_KEEP;
      case (op[`ODEC_HI])
        4'h0: c = `ODEC_FP_TEST;
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
          if (op == 8'h42) begin
            h = `ODEC_FP_CLR;
            c = `ODEC_FP_CLR;
          end else if (lo == 4'hF) begin
            n = `ODEC_FP_CLR;
            z = `ODEC_FP_SET;
          end else begin
            n = (lo == 4'h4) ? `ODEC_FP_CLR : `ODEC_FP_TEST;
            z = `ODEC_FP_TEST;
            if (lo == 4'h3)
              c = `ODEC_FP_SET;
            else if (lo < 4'hA)
              c = `ODEC_FP_TEST;
          end
        end
        4'h8: begin
          if (lo == 4'h0) begin
            h = `ODEC_FP_STACK;
            i = `ODEC_FP_STACK;
            n = `ODEC_FP_STACK;
            z = `ODEC_FP_STACK;
            c = `ODEC_FP_STACK;
          end else if (lo == 4'h3)
            i = `ODEC_FP_SET;
          else if (lo == 4'hE || lo == 4'hF)
            i = `ODEC_FP_CLR;
        end
        4'h9: begin
          if (lo == 4'h8) c = `ODEC_FP_CLR;
          if (lo == 4'h9) c = `ODEC_FP_SET;
          if (lo == 4'hA) i = `ODEC_FP_CLR;
          if (lo == 4'hB) i = `ODEC_FP_SET;
        end
        4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
          if (lo != 4'hC && lo != 4'hD) begin
            n = `ODEC_FP_TEST;
            z = `ODEC_FP_TEST;
            if (lo <= 4'h3 || lo == 4'h9 || lo == 4'hB)
              c = `ODEC_FP_TEST;
            if (lo == 4'h9 || lo == 4'hB)
              h = `ODEC_FP_TEST;
          end
        end
        default: c = `ODEC_FP_KEEP;
      endcase
      fpol_of = {h, i, n, z, c};
    end
  endfunction

  // length follows the mode column
  function [1:0] len_of;
    input [`ODEC_MODE_W-1:0] m;
    begin
      if (m[`ODEC_M_ABS] || m[`ODEC_M_WOFF] || m[`ODEC_M_BITTEST])
        len_of = `ODEC_LEN3;
      else if (m[`ODEC_M_IMPL] || m[`ODEC_M_RIDX])
        len_of = `ODEC_LEN1;
      else
        len_of = `ODEC_LEN2;
    end
  endfunction

  // registered read; illegal codes collapse to a one-byte no-op
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_out    <= {{(`ODEC_MODE_W-1){1'b0}}, 1'b1};
      len_out     <= `ODEC_LEN1;
      illegal_out <= 1'b0;
      fpol_out    <= {`ODEC_FPOL_W{1'b0}};
    end else if (legal_of(opcode_in)) begin
      mode_out    <= mode_of(opcode_in);
      len_out     <= len_of(mode_of(opcode_in));
      illegal_out <= 1'b0;
      fpol_out    <= fpol_of(opcode_in);
    end else begin
      mode_out    <= {{(`ODEC_MODE_W-1){1'b0}}, 1'b1};
      len_out     <= `ODEC_LEN1;
      illegal_out <= 1'b1;
      fpol_out    <= {`ODEC_FPOL_W{1'b0}};
    end
  end

endmodule // odec_attr_rom

// ---- verilog/odec_decoder.v ----
// opcode decode and effective address generation for an 8-bit core
// assumes a synchronous memory: data valid the cycle after a read strobe
// Functional notes
// (RULE_01) every opcode maps to exactly one of ten addressing modes
// (RULE_02) high nibble picks class and mode, low nibble picks operation
// (RULE_03) memory operands use the computed effective address
// (RULE_04) implied instructions need only the opcode and are one byte
// (RULE_05) constant mode: address is pc plus one, pc advances two
// (RULE_06) page-zero mode: high byte zero, low byte from next byte
// (RULE_07) absolute mode: two following bytes high then low, pc plus three
// (RULE_08) register-indexed mode: address is index, high zero, pc plus one
// (RULE_09) byte-offset mode: index plus byte, carry into high byte
// (RULE_10) indexed without offset is one byte, nothing exceeds three bytes
// (RULE_11) each flag: test, keep, clear, set or reload from stack
// (RULE_12) half carry is the carry out of bit three
// (RULE_13) word-offset mode: index plus sixteen-bit offset, pc plus three
// (RULE_14) branch target is pc plus two plus signed offset byte
// (RULE_15) bit modify: bit number from opcode, page-zero byte address
// (RULE_16) bit test copies bit to carry, target pc plus three plus offset
// (RULE_17) unmapped opcodes flagged illegal, handled as one-byte no-op
`timescale 1ns/1ns
`include "odec_map.vh"

module odec_decoder (
  // clock and reset
  input  wire                      clk_in,
  input  wire                      resetn_in,
  // decode request
  input  wire                      start_in,
  input  wire [15:0]               pc_in,
  input  wire [7:0]                index_in,
  input  wire [4:0]                flags_in,
  input  wire                      irq_line_in,
  // half carry operands
  input  wire [7:0]                alu_a_in,
  input  wire [7:0]                alu_b_in,
  input  wire                      alu_cin_in,
  // core memory bus
  output reg  [15:0]               mem_addr_out,
  output reg                       mem_rd_out,
  input  wire [7:0]                mem_rdata_in,
  // decode result
  output reg                       busy_out,
  output reg                       done_out,
  output reg  [7:0]                opcode_out,
  output reg  [`ODEC_MODE_W-1:0]   mode_out,
  output reg  [1:0]                length_out,
  output reg                       illegal_out,
  output reg                       mem_ref_out,
  output reg  [15:0]               ea_out,
  output reg  [15:0]               pc_next_out,
  output reg                       branch_taken_out,
  output reg  [`ODEC_FPOL_W-1:0]   flag_policy_out,
  output reg  [7:0]                bit_mask_out,
  output reg                       bit_set_out,
  output reg                       bit_carry_out,
  output reg                       half_carry_out
);

  // one-hot states
  localparam [10:0] S_IDLE = 11'h001;
  localparam [10:0] S_OPA  = 11'h002;
  localparam [10:0] S_OPD  = 11'h004;
  localparam [10:0] S_DEC  = 11'h008;
  localparam [10:0] S_B1A  = 11'h010;
  localparam [10:0] S_B1D  = 11'h020;
  localparam [10:0] S_B2A  = 11'h040;
  localparam [10:0] S_B2D  = 11'h080;
  localparam [10:0] S_BTA  = 11'h100;
  localparam [10:0] S_BTD  = 11'h200;
  localparam [10:0] S_FIN  = 11'h400;

  reg  [10:0]              state_reg;
  reg  [15:0]              pc_reg;
  reg  [7:0]               index_reg;
  reg  [4:0]               flags_reg;
  reg                      irq_reg;
  reg  [7:0]               op_reg;
  reg  [7:0]               b1_reg;
  reg  [7:0]               b2_reg;
  reg  [7:0]               tbyte_reg;
  wire [`ODEC_MODE_W-1:0]  rom_mode;
  wire [1:0]               rom_len;
  wire                     rom_illegal;
  wire [`ODEC_FPOL_W-1:0]  rom_fpol;

  // attribute table sampled as the opcode byte arrives
  odec_attr_rom u_rom (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .opcode_in   (mem_rdata_in),
    .mode_out    (rom_mode),
    .len_out     (rom_len),
    .illegal_out (rom_illegal),
    .fpol_out    (rom_fpol)
  );

  // sign-extended relative target
  function [15:0] rel_target;
    input [15:0] base;
    input [7:0]  off;
    begin
      rel_target = base + {{8{off[7]}}, off};
    end
  endfunction

  // branch condition from the low nibble of a relative opcode
  function br_cond;
    input [3:0] lo;
    input [4:0] f;
    input       irq;
    begin
      case (lo[3:1])
        3'h0: br_cond = 1'b1;
        3'h1: br_cond = !(f[`ODEC_F_C] | f[`ODEC_F_Z]);
        3'h2: br_cond = !f[`ODEC_F_C];
        3'h3: br_cond = !f[`ODEC_F_Z];
        3'h4: br_cond = !f[`ODEC_F_H];
        3'h5: br_cond = !f[`ODEC_F_N];
        3'h6: br_cond = !f[`ODEC_F_I];
        default: br_cond = !irq;
      endcase
      br_cond = br_cond ^ lo[0];
    end
  endfunction

  // effective address and next pc for the decoded instruction
  reg  [15:0] ea_next;
  reg  [15:0] pc_next;
  reg         taken_next;
  reg         tbit;
  reg  [8:0]  boff_sum;
  always @* begin
    tbit       = tbyte_reg[op_reg[`ODEC_BITNUM]];
    boff_sum   = {1'b0, index_reg} + {1'b0, b1_reg};
    ea_next    = `ODEC_ZERO16;
    taken_next = 1'b0;
    pc_next    = pc_reg + {14'h0000, length_out};
    case (1'b1)
      mode_out[`ODEC_M_CONST]:  ea_next = pc_reg + `ODEC_ONE16; // RULE_05
      mode_out[`ODEC_M_PAGE0],
      mode_out[`ODEC_M_BITMOD]:                                 // RULE_15
        ea_next = {`ODEC_ZERO8, b1_reg};                         // RULE_06
      mode_out[`ODEC_M_ABS]:    ea_next = {b1_reg, b2_reg};      // RULE_07
      mode_out[`ODEC_M_RIDX]:   ea_next = {`ODEC_ZERO8, index_reg}; // RULE_08
      mode_out[`ODEC_M_BOFF]:   ea_next = {7'h00, boff_sum};     // RULE_09
      mode_out[`ODEC_M_WOFF]:                                    // RULE_13
        ea_next = {b1_reg, b2_reg} + {`ODEC_ZERO8, index_reg};
      mode_out[`ODEC_M_BRANCH]: begin
        taken_next = (op_reg == `ODEC_OP_BSR) ||
                     br_cond(op_reg[`ODEC_LO], flags_reg, irq_reg);
        ea_next    = taken_next ?                                // RULE_14
                     rel_target(pc_reg + `ODEC_TWO16, b1_reg) :
                     pc_reg + `ODEC_TWO16;
      end
      mode_out[`ODEC_M_BITTEST]: begin
        ea_next    = {`ODEC_ZERO8, b1_reg};
        taken_next = tbit ^ op_reg[`ODEC_BITPOL];
      end
      default: ea_next = `ODEC_ZERO16;                          // RULE_04
    endcase
    // taken branches and jumps redirect the program counter
    if (mode_out[`ODEC_M_BRANCH] && taken_next)
      pc_next = ea_next;
    else if (mode_out[`ODEC_M_BITTEST] && taken_next)           // RULE_16
      pc_next = rel_target(pc_reg + `ODEC_THREE16, b2_reg);
    else if (op_reg[`ODEC_HI] >= 4'hB && !illegal_out &&
             (op_reg[`ODEC_LO] == 4'hC || op_reg[`ODEC_LO] == 4'hD))
      pc_next = ea_next;
  end

  // sequencer: fetch opcode, then operand bytes, then tested byte
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg        <= S_IDLE;
      pc_reg           <= `ODEC_ZERO16;
      index_reg        <= `ODEC_ZERO8;
      flags_reg        <= 5'h00;
      irq_reg          <= 1'b0;
      op_reg           <= `ODEC_OP_NOP;
      b1_reg           <= `ODEC_ZERO8;
      b2_reg           <= `ODEC_ZERO8;
      tbyte_reg        <= `ODEC_ZERO8;
      mem_addr_out     <= `ODEC_ZERO16;
      mem_rd_out       <= 1'b0;
      busy_out         <= 1'b0;
      done_out         <= 1'b0;
      opcode_out       <= `ODEC_OP_NOP;
      mode_out         <= {{(`ODEC_MODE_W-1){1'b0}}, 1'b1};
      length_out       <= `ODEC_LEN1;
      illegal_out      <= 1'b0;
      mem_ref_out      <= 1'b0;
      ea_out           <= `ODEC_ZERO16;
      pc_next_out      <= `ODEC_ZERO16;
      branch_taken_out <= 1'b0;
      flag_policy_out  <= {`ODEC_FPOL_W{1'b0}};
      bit_mask_out     <= `ODEC_ZERO8;
      bit_set_out      <= 1'b0;
      bit_carry_out    <= 1'b0;
      half_carry_out   <= 1'b0;
    end else begin
      done_out   <= 1'b0;
      mem_rd_out <= 1'b0;
      // carry out of bit three of the low nibble sum
      half_carry_out <= ({1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]} +
                         {4'h0, alu_cin_in}) > 5'h0F;            // RULE_12
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            pc_reg       <= pc_in;
            index_reg    <= index_in;
            flags_reg    <= flags_in;
            irq_reg      <= irq_line_in;
            mem_addr_out <= pc_in;
            mem_rd_out   <= 1'b1;
            busy_out     <= 1'b1;
            state_reg    <= S_OPA;
          end
        end
        S_OPA: state_reg <= S_OPD;
        S_OPD: begin
          op_reg    <= mem_rdata_in;                             // RULE_02
          state_reg <= S_DEC;
        end
        S_DEC: begin
          opcode_out      <= op_reg;
          mode_out        <= rom_mode;                           // RULE_01
          length_out      <= rom_len;                            // RULE_10
          illegal_out     <= rom_illegal;                        // RULE_17
          flag_policy_out <= rom_fpol;                           // RULE_11
          if (rom_len == `ODEC_LEN1) begin
            state_reg <= S_FIN;
          end else begin
            mem_addr_out <= pc_reg + `ODEC_ONE16;
            mem_rd_out   <= 1'b1;
            state_reg    <= S_B1A;
          end
        end
        S_B1A: state_reg <= S_B1D;
        S_B1D: begin
          b1_reg <= mem_rdata_in;
          if (length_out == `ODEC_LEN3) begin
            mem_addr_out <= pc_reg + `ODEC_TWO16;
            mem_rd_out   <= 1'b1;
            state_reg    <= S_B2A;
          end else begin
            state_reg <= S_FIN;
          end
        end
        S_B2A: state_reg <= S_B2D;
        S_B2D: begin
          b2_reg <= mem_rdata_in;
          if (mode_out[`ODEC_M_BITTEST]) begin
            mem_addr_out <= {`ODEC_ZERO8, b1_reg};
            mem_rd_out   <= 1'b1;
            state_reg    <= S_BTA;
          end else begin
            state_reg <= S_FIN;
          end
        end
        S_BTA: state_reg <= S_BTD;
        S_BTD: begin
          tbyte_reg <= mem_rdata_in;
          state_reg <= S_FIN;
        end
        S_FIN: begin
          ea_out           <= ea_next;                           // RULE_03
          pc_next_out      <= pc_next;
          branch_taken_out <= taken_next;
          mem_ref_out      <= !(mode_out[`ODEC_M_IMPL] ||
                                mode_out[`ODEC_M_BRANCH]);
          bit_mask_out     <= 8'h01 << op_reg[`ODEC_BITNUM];      // RULE_15
          bit_set_out      <= !op_reg[`ODEC_BITPOL];
          bit_carry_out    <= tbit;                               // RULE_16
          busy_out         <= 1'b0;
          done_out         <= 1'b1;
          state_reg        <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // odec_decoder

// ---- test/odec_mem_model.sv ----
// memory model on the decoder's read port
// assumes one-cycle read strobes and no wait states
`timescale 1ns/1ns
module odec_mem_model (
  // clock and read port
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:65535];
  // fill with a known pattern so no read returns unknowns
  initial begin
    foreach (mem[i]) mem[i] = 8'(i);
  end
  // data the cycle after the strobe, a changing value otherwise
  always @(posedge clk_in) begin
    if (rd_in) rdata_out <= mem[addr_in];
    else rdata_out <= ~rdata_out;
  end
endmodule // odec_mem_model

// ---- test/odec_decoder_sva.sv ----
// checker for the decoder's request timing and address relations
// assumes it is bound onto odec_decoder, one clock, async low reset
`timescale 1ns/1ns
`include "odec_map.vh"
module odec_decoder_sva (
  // clock, reset, request and half carry operands
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        start_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0]  index_in,
  input wire logic [7:0]  alu_a_in,
  input wire logic [7:0]  alu_b_in,
  input wire logic        alu_cin_in,
  // decoder outputs
  input wire logic [15:0] mem_addr_out,
  input wire logic        mem_rd_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [7:0]  opcode_out,
  input wire logic [9:0]  mode_out,
  input wire logic [1:0]  length_out,
  input wire logic        illegal_out,
  input wire logic        mem_ref_out,
  input wire logic [15:0] ea_out,
  input wire logic [15:0] pc_next_out,
  input wire logic [14:0] flag_policy_out,
  input wire logic        half_carry_out
);
  logic [15:0] pc_q;
  logic [7:0]  idx_q;
  logic [3:0]  cnt_q;
  logic        run_q;
  wire         take = start_in && !busy_out;
  wire  [4:0]  hsum = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]} + {4'h0, alu_cin_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // capture request operands and count cycles since the request
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q <= 16'h0000;
      idx_q <= 8'h00;
      cnt_q <= 4'hf;
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
      if (take) begin
        pc_q <= pc_in;
        idx_q <= index_in;
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    end
  end
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_busy_run;
    busy_out [*4];
  endsequence
  AST_WALK: assert property (s_take |=> s_busy_run ##1 (done_out || busy_out))
    else $error("busy span after request too short");
  AST_FETCH: assert property (s_take |=> mem_rd_out && mem_addr_out == $past(pc_in))
    else $error("opcode fetch not at request address");
  AST_DONE_TIME: assert property (done_out |-> cnt_q == (mode_out[`ODEC_M_BITTEST] ? 4'd10 : 4'd2 + {1'b0, length_out, 1'b0}))
    else $error("done not at the cycle set by length");
  AST_DONE_PULSE: assert property (done_out |=> !done_out)
    else $error("done wider than one cycle");
  AST_ONEHOT: assert property (done_out |-> $onehot(mode_out) && length_out != 2'h0)
    else $error("mode not one of ten");
  AST_CONST: assert property (done_out && mode_out[`ODEC_M_CONST] |-> ea_out == pc_q + 16'h0001 && pc_next_out == pc_q + 16'h0002)
    else $error("constant operand address wrong");
  AST_PAGE0: assert property (done_out && mode_out[`ODEC_M_PAGE0] && opcode_out[3:1] != 3'b110 |-> ea_out[15:8] == 8'h00 && pc_next_out == pc_q + 16'h0002)
    else $error("page-zero address wrong");
  AST_RIDX: assert property (done_out && mode_out[`ODEC_M_RIDX] |-> ea_out == {8'h00, idx_q} && length_out == 2'h1)
    else $error("indexed address wrong");
  AST_BOFF: assert property (done_out && mode_out[`ODEC_M_BOFF] |-> ea_out[15:9] == 7'h00 && length_out == 2'h2)
    else $error("byte offset address out of reach");
  AST_IMPL: assert property (done_out && mode_out[`ODEC_M_IMPL] |-> length_out == 2'h1 && !mem_ref_out)
    else $error("implied instruction not one byte");
  AST_ILLEGAL: assert property (done_out && illegal_out |-> mode_out == 10'h001 && flag_policy_out == 15'h0000 && ea_out == 16'h0000)
    else $error("unmapped opcode handling wrong");
  AST_HALF: assert property (run_q |-> half_carry_out == $past(hsum[4]))
    else $error("half carry wrong");
endmodule // odec_decoder_sva
bind odec_decoder odec_decoder_sva u_odec_decoder_sva (.*);

// ---- test/opcode_decode_and_ea_gen_tb.sv ----
// self-checking bench for the opcode decoder and address generator
// assumes the decoder, its checker and the memory model are compiled first
`timescale 1ns/1ns
module opcode_decode_and_ea_gen_tb;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        start_in = 1'b0;
  logic        irq_line_in = 1'b0;
  logic        alu_cin_in = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0]  index_in = 8'h00;
  logic [4:0]  flags_in = 5'h00;
  logic [7:0]  alu_a_in = 8'h00;
  logic [7:0]  alu_b_in = 8'h00;
  wire  [7:0]  mem_rdata_in;
  wire  [15:0] mem_addr_out, ea_out, pc_next_out;
  wire  [14:0] flag_policy_out;
  wire  [9:0]  mode_out;
  wire  [7:0]  opcode_out, bit_mask_out;
  wire  [1:0]  length_out;
  wire         mem_rd_out, busy_out, done_out, illegal_out, mem_ref_out;
  wire         branch_taken_out, bit_set_out, bit_carry_out, half_carry_out;
  int          fail_count = 0;
  int          tests_run = 0;
  logic [3:0]  hs [8] = '{4'h0, 4'h1, 4'h2, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [7:0]  cor [15] = '{8'h31, 8'h9E, 8'hA7, 8'hAD, 8'hA6, 8'h7C, 8'h42,
    8'h80, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'hE6, 8'hDE, 8'hCC};
  logic [15:0] pol [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0048,
    16'h0048, 16'h2002, 16'h4924, 16'h0002, 16'h0003, 16'h0400, 16'h0600,
    16'h0048, 16'h0048, 16'h0000};
  odec_decoder u_odec_decoder (.*);
  odec_mem_model u_odec_mem_model (
    .clk_in    (clk_in),
    .rd_in     (mem_rd_out),
    .addr_in   (mem_addr_out),
    .rdata_out (mem_rdata_in)
  );
  // clock and random half-carry operands
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    alu_a_in <= 8'($urandom);
    alu_b_in <= 8'($urandom);
    alu_cin_in <= 1'($urandom);
  end
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rst_chk;
    chk("rst_opcode", 16'h009D, {8'h00, opcode_out});
    chk("rst_mode", 16'h0003, {5'h00, mode_out, length_out == 2'h1});
    chk("rst_done", 16'h0000, {14'h0, done_out, busy_out});
  endtask
  // one decode: load memory, request, refuse a second request, compare
  task automatic go(input logic [7:0] op, idx, b1, b2, input logic [15:0] pc, pl);
    logic [7:0]  tb, cv;
    logic [4:0]  fl;
    logic [3:0]  hi, lo, md;
    logic [1:0]  ln;
    logic [15:0] ea, pn;
    logic        irq, tk, il;
    tb = 8'($urandom);
    fl = 5'($urandom);
    irq = 1'($urandom);
    hi = op[7:4];
    lo = op[3:0];
    u_odec_mem_model.mem[pc] = op;
    u_odec_mem_model.mem[pc + 16'h0001] = b1;
    u_odec_mem_model.mem[pc + 16'h0002] = b2;
    u_odec_mem_model.mem[{8'h00, b1}] = tb;
    cv = {~irq, ~fl[3], ~fl[2], ~fl[4], ~fl[1], ~fl[0], ~(fl[0] | fl[1]), 1'b1};
    tk = 1'b0;
    ln = 2'h2;
    ea = {8'h00, b1};
    case (hi)
      4'h0: begin md = 4'd9; ln = 2'h3; tk = tb[lo[3:1]] ^ lo[0]; end
      4'h1: md = 4'd8;
      4'h2: begin md = 4'd7; tk = cv[lo[3:1]] ^ lo[0]; end
      4'h3, 4'hB: md = 4'd2;
      4'h6, 4'hE: begin md = 4'd5; ea = {8'h00, idx} + {8'h00, b1}; end
      4'h7, 4'hF: begin md = 4'd4; ln = 2'h1; ea = {8'h00, idx}; end
      4'hA: begin md = 4'd1; ea = pc + 16'h0001; end
      4'hC: begin md = 4'd3; ln = 2'h3; ea = {b1, b2}; end
      4'hD: begin md = 4'd6; ln = 2'h3; ea = {b1, b2} + {8'h00, idx}; end
      default: begin md = 4'd0; ln = 2'h1; ea = 16'h0000; end
    endcase
    if (op == 8'hAD) begin md = 4'd7; tk = 1'b1; end
    il = (op == 8'h31 || op == 8'h9E || op == 8'hA7);
    if (il) begin md = 4'd0; ln = 2'h1; ea = 16'h0000; end
    pn = pc + {14'h0, ln};
    if (md == 4'd7) begin ea = pc + 16'h0002 + (tk ? {{8{b1[7]}}, b1} : 16'h0000); pn = ea; end
    if (md == 4'd9 && tk) pn = pn + {{8{b2[7]}}, b2};
    if (hi > 4'hA && lo[3:1] == 3'b110) pn = ea;
    @(posedge clk_in);
    start_in <= 1'b1;
    pc_in <= pc;
    index_in <= idx;
    flags_in <= fl;
    irq_line_in <= irq;
    @(posedge clk_in);
    start_in <= 1'b0;
    @(posedge clk_in);
    start_in <= 1'b1;
    pc_in <= ~pc;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (30) begin
      @(negedge clk_in);
      if (done_out === 1'b1) break;
    end
    chk("done", 16'h0001, {15'h0, done_out});
    chk("opcode", {8'h00, op}, {8'h00, opcode_out});
    chk("mode", 16'h0001 << md, {6'h00, mode_out});
    chk("length", {14'h0, ln}, {14'h0, length_out});
    chk("illegal", {15'h0, il}, {15'h0, illegal_out});
    chk("ea", ea, ea_out);
    chk("pc_next", pn, pc_next_out);
    chk("mem_ref", {15'h0, md != 4'd0 && md != 4'd7}, {15'h0, mem_ref_out});
    if (md == 4'd7 || md == 4'd9) chk("taken", {15'h0, tk}, {15'h0, branch_taken_out});
    if (md == 4'd9) chk("bit_carry", {15'h0, tb[lo[3:1]]}, {15'h0, bit_carry_out});
    if (md >= 4'd8) chk("bit_mask", {7'h0, ~lo[0], 8'h01 << lo[3:1]}, {7'h0, bit_set_out, bit_mask_out});
    if (pl != 16'hFFFF) chk("policy", pl, {1'b0, flag_policy_out});
  endtask
  // watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(85381));
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    rst_chk();
    for (int i = 0; i < 384; i++) go({hs[i % 8], 4'(i / 8)}, 8'($urandom), 8'($urandom), 8'($urandom), (16'($urandom) & 16'h7eff) | 16'h0100, 16'hFFFF);
    @(posedge clk_in);
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b0;
    @(negedge clk_in);
    rst_chk();
    @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 15; i++) go(cor[i], 8'hFF, 8'hFF, 8'hFF, 16'h7FFD, pol[i]);
    print_verdict();
  end
endmodule // opcode_decode_and_ea_gen_tb
